/* File: rtl/scss_pkg.sv */
`default_nettype none
package scss_pkg;

    // Bus clock and register map.
    localparam int unsigned PCLK_HZ         = 20_000_000;
    localparam int unsigned PCLK_NS         = 50;
    localparam logic [11:0] ADDR_OSC_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_INT_STATUS = 12'h004;
    localparam logic [11:0] ADDR_INT_CLEAR  = 12'h008;
    localparam logic [11:0] ADDR_INT_ENABLE = 12'h00C;

    // Field positions of the oscillator control register.
    localparam int unsigned SCS_BIT   = 0;
    localparam int unsigned LTS_BIT   = 1;
    localparam int unsigned HTS_BIT   = 2;
    localparam int unsigned STARTUP_TIMEOUT_STATUS_BIT  = 3;
    localparam int unsigned INTERNAL_FREQ_SELECT_LSB  = 4;
    localparam int unsigned INTERNAL_FREQ_SELECT_MSB  = 6;
    localparam logic [2:0]  INTERNAL_FREQ_SELECT_RESET = 3'h6;
    localparam logic [2:0]  INTERNAL_FREQ_SELECT_LF    = 3'h0;
    localparam logic [2:0]  INTERNAL_FREQ_SELECT_TOP   = 3'h7;
    localparam logic        SCS_RESET  = 1'h0;

    // Event bits shared by status, clear and enable registers.
    localparam int unsigned EV_W        = 3;
    localparam int unsigned EV_FAIL     = 0;
    localparam int unsigned EV_OST_DONE = 1;
    localparam int unsigned EV_HF_READY = 2;

    // Timing: start-up timer length, warm-up times and monitor window.
    localparam logic [10:0] OST_COUNT      = 11'h400;
    localparam int unsigned HF_WARM_NS     = 1000;
    localparam logic [4:0]  HF_WARM_CYC    = 5'((HF_WARM_NS + PCLK_NS - 1) / PCLK_NS);
    localparam logic [1:0]  LF_WARM_TICKS  = 2'h2;
    localparam logic [2:0]  FAILSAFE_CLOCK_MONITOR_LF_TICKS  = 3'h4;

    // Internal oscillator rates, produced by phase accumulators on pclk.
    localparam int unsigned NCO_W  = 24;
    localparam longint      HF_HZ  = 8_000_000;
    localparam longint      LF_HZ  = 31_000;
    localparam logic [23:0] HF_INC = 24'((HF_HZ << NCO_W) / PCLK_HZ);
    localparam logic [23:0] LF_INC = 24'((LF_HZ << NCO_W) / PCLK_HZ);

    // Clock modes in the order of the configuration field codes 0 to 7.
    typedef enum logic [2:0] {
        external_clock_mode,
        low_power_crystal_mode,
        medium_gain_crystal_mode,
        high_gain_crystal_mode,
        resistor_capacitor_mode,
        resistor_capacitor_io_mode,
        internal_clock_out_mode,
        internal_clock_io_mode
    } scss_mode_type;

    typedef enum logic [1:0] {
        CS_START,
        CS_OST,
        CS_CFG,
        CS_FAIL
    } scss_state_type;

    // Configuration word fields that steer this block.
    typedef struct packed {
        scss_mode_type mode;
        logic          two_speed;
        logic          failsafe_clock_monitor_en;
    } scss_cfg_type;

endpackage
`default_nettype wire

/* File: rtl/scss_clock_select.sv */
// Notes on behaviour
// - One of eight modes from config field.
// - External clock on first pin; second freed.
// - Low-power, medium, high gain crystal modes.
// - RC mode drives clock/4 on second pin.
// - RC I/O mode frees second pin.
// - Internal out mode: clock/4 out, first freed.
// - Internal I/O mode frees both pins.
// - Monitor falls back to internal on loss.
// - Frequency field picks 8 MHz..125k, 31k; reset 110.
// - Timeout status 1 only on configured source.
// - Timeout status resets 0 for two-speed/monitor.
// - HF stable bit shows high oscillator ready.
// - LF stable bit shows low oscillator ready.
// - Select bit 1 forces internal; resets 0.
// - Top control bit reads zero.
// - Crystal start-up counts 1024 cycles, holds CPU unless two-speed.
// - Internal 8 MHz and 31 kHz sources.
`timescale 1ns/1ps
`default_nettype none
module scss_clock_select (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    input  wire scss_pkg::scss_cfg_type cfg,
    input  wire logic                  first_oscillator_pin,
    output logic                       second_oscillator_pin_out,
    output logic                       second_oscillator_pin_oe_n,
    output logic                       first_pin_gpio_free,
    output logic                       second_pin_gpio_free,
    output logic                       sys_clk_en,
    output logic                       cpu_hold,
    output logic                       irq
);

    // Mode classes used in several places.
    function automatic logic is_crystal(input scss_pkg::scss_mode_type m);
        is_crystal = (m == scss_pkg::low_power_crystal_mode) ||
                     (m == scss_pkg::medium_gain_crystal_mode) ||
                     (m == scss_pkg::high_gain_crystal_mode);
    endfunction

    function automatic logic is_internal(input scss_pkg::scss_mode_type m);
        is_internal = (m == scss_pkg::internal_clock_out_mode) ||
                      (m == scss_pkg::internal_clock_io_mode);
    endfunction

    // Registers.
    scss_pkg::scss_cfg_type   cfg_r, cfg_nxt;
    scss_pkg::scss_state_type state_r, state_nxt;
    logic [2:0]  sync_r, sync_nxt;
    logic [10:0] ost_cnt_r, ost_cnt_nxt;
    logic [2:0]  failsafe_clock_monitor_cnt_r, failsafe_clock_monitor_cnt_nxt;
    logic [23:0] hf_acc_r, hf_acc_nxt;
    logic [23:0] lf_acc_r, lf_acc_nxt;
    logic [4:0]  hf_warm_r, hf_warm_nxt;
    logic [1:0]  lf_warm_r, lf_warm_nxt;
    logic [1:0]  div_r, div_nxt;
    logic        startup_timeout_status_r, startup_timeout_status_nxt;
    logic        tick_r, tick_nxt;
    logic        hold_r, hold_nxt;
    logic        o2_out_r, o2_out_nxt;
    logic        o2_oe_n_r, o2_oe_n_nxt;
    logic        o1_free_r, o1_free_nxt;
    logic        o2_free_r, o2_free_nxt;
    logic [2:0]  internal_freq_select_r, internal_freq_select_nxt;
    logic        scs_r, scs_nxt;
    logic [scss_pkg::EV_W-1:0] ev_st_r, ev_st_nxt;
    logic [scss_pkg::EV_W-1:0] ev_en_r, ev_en_nxt;
    logic        pready_r, pready_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        pslverr_r, pslverr_nxt;
    logic        irq_r, irq_nxt;

    // Shared combinational terms.
    logic        ext_edge;
    logic        hf_tick;
    logic        lf_tick;
    logic        hf_on;
    logic        hf_internal_stable;
    logic        lf_internal_stable;
    logic        int_tick;
    logic        ext_mode;
    logic        on_cfg;
    logic        fail_det;
    logic [scss_pkg::EV_W-1:0] ev;
    logic        wr_done;
    logic [7:0]  ctrl_rd;

    // Oscillator engine: pin synchroniser, internal oscillators, start-up
    // timer, fail-safe monitor and source selection.  The system clock is
    // an enable pulse train, so any switch lands between whole pulses and
    // can never produce a runt.
    always_comb begin
        cfg_nxt      = cfg_r;
        state_nxt    = state_r;
        ost_cnt_nxt  = ost_cnt_r;
        failsafe_clock_monitor_cnt_nxt = failsafe_clock_monitor_cnt_r;
        hf_warm_nxt  = hf_warm_r;
        lf_warm_nxt  = lf_warm_r;
        div_nxt      = div_r;
        // Only the second and third stages feed the edge detector.
        sync_nxt = {sync_r[1:0], first_oscillator_pin};
        ext_edge = sync_r[1] & ~sync_r[2];
        // High oscillator is divided by shifting its step.
        {hf_tick, hf_acc_nxt} = {1'b0, hf_acc_r} +
                                {1'b0, scss_pkg::HF_INC >> (scss_pkg::INTERNAL_FREQ_SELECT_TOP - internal_freq_select_r)};
        {lf_tick, lf_acc_nxt} = {1'b0, lf_acc_r} + {1'b0, scss_pkg::LF_INC};
        ext_mode = !is_internal(cfg_r.mode);
        on_cfg   = (state_r == scss_pkg::CS_CFG) && !scs_r;
        hf_on    = (internal_freq_select_r != scss_pkg::INTERNAL_FREQ_SELECT_LF) && !(on_cfg && ext_mode);
        hf_internal_stable      = hf_on && (hf_warm_r == scss_pkg::HF_WARM_CYC);
        lf_internal_stable      = (lf_warm_r == scss_pkg::LF_WARM_TICKS);
        // Stay on the low oscillator until the high one is stable.
        int_tick = (hf_on && hf_internal_stable) ? hf_tick : lf_tick;
        // Warm-up of the high oscillator restarts whenever it is off.
        if (!hf_on) begin
            hf_warm_nxt = '0;
        end else if (!hf_internal_stable) begin
            hf_warm_nxt = hf_warm_r + 5'h01;
        end
        if (lf_tick && !lf_internal_stable) begin
            lf_warm_nxt = lf_warm_r + 2'h1;
        end
        // Fail-safe watch: low-oscillator ticks without an external edge.
        if (ext_edge) begin
            failsafe_clock_monitor_cnt_nxt = '0;
        end else if (lf_tick && failsafe_clock_monitor_cnt_r != scss_pkg::FAILSAFE_CLOCK_MONITOR_LF_TICKS) begin
            failsafe_clock_monitor_cnt_nxt = failsafe_clock_monitor_cnt_r + 3'h1;
        end
        fail_det = cfg_r.failsafe_clock_monitor_en && ext_mode && (state_r == scss_pkg::CS_CFG) &&
                   (failsafe_clock_monitor_cnt_r == scss_pkg::FAILSAFE_CLOCK_MONITOR_LF_TICKS);
        ev = '0;
        ev[scss_pkg::EV_HF_READY] = hf_on && (hf_warm_r == scss_pkg::HF_WARM_CYC - 5'h01);
        case (state_r)
            scss_pkg::CS_START: begin
                // The configuration word is caught once after reset.
                cfg_nxt      = cfg;
                ost_cnt_nxt  = '0;
                failsafe_clock_monitor_cnt_nxt = '0;
                state_nxt    = is_crystal(cfg.mode) ? scss_pkg::CS_OST : scss_pkg::CS_CFG;
            end
            scss_pkg::CS_OST: begin
                if (ext_edge) begin
                    ost_cnt_nxt = ost_cnt_r + 11'h001;
                end
                if (ost_cnt_r == scss_pkg::OST_COUNT) begin
                    state_nxt    = scss_pkg::CS_CFG;
                    failsafe_clock_monitor_cnt_nxt = '0;
                    ev[scss_pkg::EV_OST_DONE] = 1'b1;
                end
            end
            scss_pkg::CS_CFG: begin
                if (fail_det) begin
                    state_nxt = scss_pkg::CS_FAIL;
                    ev[scss_pkg::EV_FAIL] = 1'b1;
                end
            end
            scss_pkg::CS_FAIL: begin
                state_nxt = scss_pkg::CS_FAIL;
            end
            default: begin
                state_nxt = scss_pkg::CS_START;
            end
        endcase
        // Source mux: configured external source or an internal one.
        if (state_r == scss_pkg::CS_START) begin
            tick_nxt = 1'b0;
        end else if (on_cfg && ext_mode) begin
            tick_nxt = ext_edge;
        end else if (state_r == scss_pkg::CS_OST && !cfg_r.two_speed) begin
            tick_nxt = 1'b0;
        end else begin
            tick_nxt = int_tick;
        end
        // A switch may line up ticks of two sources; never emit two in a row.
        if (tick_r) begin
            tick_nxt = 1'b0;
        end
        hold_nxt = (state_r == scss_pkg::CS_START) ||
                   (state_nxt == scss_pkg::CS_OST && !cfg_r.two_speed);
        // Timeout status follows the active source once running.
        if (state_r == scss_pkg::CS_START) begin
            startup_timeout_status_nxt = !((cfg.two_speed && is_crystal(cfg.mode)) || cfg.failsafe_clock_monitor_en);
        end else begin
            startup_timeout_status_nxt = (state_r == scss_pkg::CS_CFG) && !scs_r && ext_mode;
        end
        // Clock output at a quarter of the system clock rate.
        if (tick_r) begin
            div_nxt = div_r + 2'h1;
        end
        o2_out_nxt  = div_r[1];
        o2_oe_n_nxt = !((cfg_r.mode == scss_pkg::resistor_capacitor_mode) ||
                        (cfg_r.mode == scss_pkg::internal_clock_out_mode));
        o1_free_nxt = is_internal(cfg_r.mode);
        o2_free_nxt = (cfg_r.mode == scss_pkg::external_clock_mode) ||
                      (cfg_r.mode == scss_pkg::resistor_capacitor_io_mode) ||
                      (cfg_r.mode == scss_pkg::internal_clock_io_mode);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r      <= '0;
            state_r    <= scss_pkg::CS_START;
            sync_r     <= 3'h7; // Pin counts as high until a real low is seen.
            ost_cnt_r  <= '0;
            failsafe_clock_monitor_cnt_r <= '0;
            hf_acc_r   <= '0;
            lf_acc_r   <= '0;
            hf_warm_r  <= '0;
            lf_warm_r  <= '0;
            div_r      <= '0;
            startup_timeout_status_r     <= 1'b0;
            tick_r     <= 1'b0;
            hold_r     <= 1'b1;
            o2_out_r   <= 1'b0;
            o2_oe_n_r  <= 1'b1;
            o1_free_r  <= 1'b0;
            o2_free_r  <= 1'b0;
        end else begin
            cfg_r      <= cfg_nxt;
            state_r    <= state_nxt;
            sync_r     <= sync_nxt;
            ost_cnt_r  <= ost_cnt_nxt;
            failsafe_clock_monitor_cnt_r <= failsafe_clock_monitor_cnt_nxt;
            hf_acc_r   <= hf_acc_nxt;
            lf_acc_r   <= lf_acc_nxt;
            hf_warm_r  <= hf_warm_nxt;
            lf_warm_r  <= lf_warm_nxt;
            div_r      <= div_nxt;
            startup_timeout_status_r     <= startup_timeout_status_nxt;
            tick_r     <= tick_nxt;
            hold_r     <= hold_nxt;
            o2_out_r   <= o2_out_nxt;
            o2_oe_n_r  <= o2_oe_n_nxt;
            o1_free_r  <= o1_free_nxt;
            o2_free_r  <= o2_free_nxt;
        end
    end

    // APB slave and software registers.  Read data is captured in the setup
    // cycle so that every bus output comes from a flip-flop; the price is
    // that status seen by a read is one cycle old.
    always_comb begin
        internal_freq_select_nxt    = internal_freq_select_r;
        scs_nxt     = scs_r;
        ev_en_nxt   = ev_en_r;
        pready_nxt  = 1'b0;
        prdata_nxt  = prdata_r;
        pslverr_nxt = pslverr_r;
        wr_done     = psel && penable && pready_r && pwrite;
        ctrl_rd     = '0;
        ctrl_rd[scss_pkg::INTERNAL_FREQ_SELECT_MSB:scss_pkg::INTERNAL_FREQ_SELECT_LSB] = internal_freq_select_r;
        ctrl_rd[scss_pkg::STARTUP_TIMEOUT_STATUS_BIT] = startup_timeout_status_r;
        ctrl_rd[scss_pkg::HTS_BIT]  = hf_internal_stable;
        ctrl_rd[scss_pkg::LTS_BIT]  = lf_internal_stable;
        ctrl_rd[scss_pkg::SCS_BIT]  = scs_r;
        if (psel && !penable) begin
            pready_nxt  = 1'b1;
            pslverr_nxt = 1'b0;
            case (paddr)
                scss_pkg::ADDR_OSC_CTRL:   prdata_nxt = {24'h000000, ctrl_rd};
                scss_pkg::ADDR_INT_STATUS: prdata_nxt = {29'h00000000, ev_st_r};
                scss_pkg::ADDR_INT_CLEAR:  prdata_nxt = '0;
                scss_pkg::ADDR_INT_ENABLE: prdata_nxt = {29'h00000000, ev_en_r};
                default: begin
                    prdata_nxt  = '0;
                    pslverr_nxt = 1'b1;
                end
            endcase
        end
        // Sticky status: a new event wins over a clear in the same cycle.
        ev_st_nxt = ev_st_r | ev;
        if (wr_done && pstrb[0]) begin
            case (paddr)
                scss_pkg::ADDR_OSC_CTRL: begin
                    internal_freq_select_nxt = pwdata[scss_pkg::INTERNAL_FREQ_SELECT_MSB:scss_pkg::INTERNAL_FREQ_SELECT_LSB];
                    scs_nxt  = pwdata[scss_pkg::SCS_BIT];
                end
                scss_pkg::ADDR_INT_CLEAR: begin
                    ev_st_nxt = (ev_st_r & ~pwdata[scss_pkg::EV_W-1:0]) | ev;
                end
                scss_pkg::ADDR_INT_ENABLE: begin
                    ev_en_nxt = pwdata[scss_pkg::EV_W-1:0];
                end
                default: begin
                    ev_en_nxt = ev_en_r;
                end
            endcase
        end
        irq_nxt = |(ev_st_nxt & ev_en_nxt);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            internal_freq_select_r    <= scss_pkg::INTERNAL_FREQ_SELECT_RESET;
            scs_r     <= scss_pkg::SCS_RESET;
            ev_st_r   <= '0;
            ev_en_r   <= '0;
            pready_r  <= 1'b0;
            prdata_r  <= '0;
            pslverr_r <= 1'b0;
            irq_r     <= 1'b0;
        end else begin
            internal_freq_select_r    <= internal_freq_select_nxt;
            scs_r     <= scs_nxt;
            ev_st_r   <= ev_st_nxt;
            ev_en_r   <= ev_en_nxt;
            pready_r  <= pready_nxt;
            prdata_r  <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
            irq_r     <= irq_nxt;
        end
    end

    // Outputs straight from flip-flops.
    assign pready                     = pready_r;
    assign prdata                     = prdata_r;
    assign pslverr                    = pslverr_r;
    assign second_oscillator_pin_out  = o2_out_r;
    assign second_oscillator_pin_oe_n = o2_oe_n_r;
    assign first_pin_gpio_free        = o1_free_r;
    assign second_pin_gpio_free       = o2_free_r;
    assign sys_clk_en                 = tick_r;
    assign cpu_hold                   = hold_r;
    assign irq                        = irq_r;

endmodule
`default_nettype wire

/* File: bench/scss_osc_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Crystal or external clock source feeding the first oscillator pin.
module scss_osc_model #(
    parameter int unsigned HALF_NS = 110
) (
    input  wire logic run,
    output logic      pin
);
    // Free-running toggle while powered; a stopped source sits low, like a dead crystal.
    initial begin
        pin = 1'b0;
        forever begin
            #(HALF_NS);
            pin = run ? ~pin : 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: bench/scss_clock_select_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// Checker on the top ports; every property samples on pclk and is muted in reset.
module scss_clock_select_asserts (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    input  wire logic        second_oscillator_pin_out,
    input  wire logic        second_oscillator_pin_oe_n,
    input  wire logic        first_pin_gpio_free,
    input  wire logic        second_pin_gpio_free,
    input  wire logic        sys_clk_en,
    input  wire logic        cpu_hold
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Unmapped means outside the four word addresses.
    logic unmapped;
    assign unmapped = (paddr[11:4] != 8'h00) || (paddr[1:0] != 2'h0);

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_unmapped_err: assert property (psel && !penable && unmapped |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_err_only_bad: assert property (pready && !unmapped |-> !pslverr)
        else $error("error on mapped access");
    a_ctrl_top_zero: assert property (pready && !pwrite && paddr == 12'h000 |->
        prdata[31:7] == 25'h0)
        else $error("control upper bits not zero");
    a_out_not_gpio: assert property (
        !second_oscillator_pin_oe_n |-> !second_pin_gpio_free)
        else $error("driven pin also freed");
    a_int_out_drives: assert property (
        first_pin_gpio_free && !second_pin_gpio_free |-> !second_oscillator_pin_oe_n)
        else $error("internal out mode not driving");
    a_hold_stalls: assert property (cpu_hold |-> !sys_clk_en)
        else $error("clock runs while held");
    a_tick_single: assert property (sys_clk_en |=> !sys_clk_en)
        else $error("clock enable stretched");
    a_div_follows: assert property (
        $changed(second_oscillator_pin_out) |-> $past(sys_clk_en) || $past(sys_clk_en, 2))
        else $error("divided output moved without a tick");
endmodule
bind scss_clock_select scss_clock_select_asserts chk_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .prdata, .pslverr,
    .second_oscillator_pin_out, .second_oscillator_pin_oe_n, .first_pin_gpio_free,
    .second_pin_gpio_free, .sys_clk_en, .cpu_hold
);
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                  pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]           paddr = 12'h000;
    logic [31:0]           pwdata = 32'h0, prdata, rd;
    logic [3:0]            pstrb = 4'hF;
    logic                  pready, pslverr, run = 1'b1, pin, err;
    scss_pkg::scss_cfg_type cfg = '0;
    logic                  pin_out, oe_n, free1, free2, clk_en, hold, irq;
    int                    mismatches = 0, cmp_count = 0, cycles = 0, edges = 0;

    scss_clock_select dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .cfg(cfg), .first_oscillator_pin(pin),
        .second_oscillator_pin_out(pin_out), .second_oscillator_pin_oe_n(oe_n),
        .first_pin_gpio_free(free1), .second_pin_gpio_free(free2), .sys_clk_en(clk_en),
        .cpu_hold(hold), .irq(irq));
    scss_osc_model osc_u (.run(run), .pin(pin));

    // Clock, pin edge counter and a hang guard sized well above the whole run.
    always #25 pclk = ~pclk;
    always @(posedge pin) edges++;
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 60000) begin
            mismatches++;
            test_done();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        check(32'(n < 20), 32'h1, "ready wait");
    endtask

    // Reset with a new configuration word, since it is captured only after release.
    task automatic rst(input logic [2:0] m, input logic ts, input logic fs);
        @(posedge pclk);
        presetn <= 1'b0; cfg <= '{scss_pkg::scss_mode_type'(m), ts, fs};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1; edges = 0;
        repeat (3) @(posedge pclk);
    endtask

    task automatic t_regs;
        rst(3'h7, 1'b0, 1'b0);
        apb(1'b0, scss_pkg::ADDR_OSC_CTRL, 32'h0);
        check(rd & 32'hFF, 32'h60, "control reset");
        apb(1'b1, scss_pkg::ADDR_OSC_CTRL, 32'hFF);
        apb(1'b0, scss_pkg::ADDR_OSC_CTRL, 32'h0);
        check(rd & 32'hF1, 32'h71, "control written");
        pstrb <= 4'h0;
        apb(1'b1, scss_pkg::ADDR_OSC_CTRL, 32'h0);
        pstrb <= 4'hF;
        apb(1'b0, scss_pkg::ADDR_OSC_CTRL, 32'h0);
        check(rd & 32'hF1, 32'h71, "masked write ignored");
        apb(1'b0, 12'h010, 32'h0);
        check({31'h0, err}, 32'h1, "unmapped error");
        apb(1'b0, scss_pkg::ADDR_INT_CLEAR, 32'h0);
        check(rd, 32'h0, "clear reads zero");
        $display("test regs done");
    endtask

    // Every mode: pin release flags; the divided clock output in the RC and internal out modes only.
    task automatic t_modes;
        int en, rises;
        logic last;
        for (int m = 0; m < 8; m++) begin
            rst(3'(m), 1'b0, 1'b0);
            check({oe_n, free1, free2}, {m != 4 && m != 6, m >= 6, m == 0 || m == 5 || m == 7},
                  "pin usage");
            en = 0; rises = 0; last = pin_out;
            repeat (800) begin
                @(posedge pclk);
                en += clk_en;
                rises += (pin_out && !last);
                last = pin_out;
            end
            if (m == 4 || m == 6)
                check(32'(rises > 0 && en >= 4 * rises - 4 && en <= 4 * rises + 4),
                      32'h1, "div4");
        end
        $display("test modes done");
    endtask

    // Internal rate per frequency code, with stable flags.
    task automatic t_freq;
        int en;
        logic [2:0] codes [3] = '{3'h7, 3'h4, 3'h0};
        int exp_n [3] = '{80, 10, 0};
        rst(3'h7, 1'b0, 1'b0);
        repeat (1500) @(posedge pclk);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, scss_pkg::ADDR_OSC_CTRL, {25'h0, codes[i], 4'h0});
            repeat (60) @(posedge pclk);
            en = 0;
            repeat (200) @(posedge pclk) en += clk_en;
            check(32'(en >= exp_n[i] - 1 && en <= exp_n[i] + 2),
                  32'h1, "internal rate");
        end
        apb(1'b1, scss_pkg::ADDR_OSC_CTRL, 32'h70);
        repeat (60) @(posedge pclk);
        apb(1'b0, scss_pkg::ADDR_OSC_CTRL, 32'h0);
        check(rd[2:1], 2'h3, "stable flags");
        $display("test freq done");
    endtask

    // Crystal start-up timer, then two-speed start.
    task automatic t_ost;
        int n;
        rst(3'h1, 1'b0, 1'b0);
        check({31'h0, hold}, 32'h1, "held during start-up");
        n = 0;
        while (hold === 1'b1 && n < 9000) begin
            @(posedge pclk);
            n++;
        end
        check(32'(edges >= 1024 && edges <= 1026),
              32'h1, "start-up edge count");
        apb(1'b0, scss_pkg::ADDR_INT_STATUS, 32'h0);
        check(rd[scss_pkg::EV_OST_DONE], 32'h1, "start-up event");
        apb(1'b0, scss_pkg::ADDR_OSC_CTRL, 32'h0);
        check(rd[3], 32'h1, "timeout status on crystal");
        rst(3'h2, 1'b1, 1'b0);
        check({31'h0, hold}, 32'h0, "two-speed runs");
        apb(1'b0, scss_pkg::ADDR_OSC_CTRL, 32'h0);
        check(rd[3], 32'h0, "timeout status two-speed");
        $display("test ost done");
    endtask

    // Select bit, then loss of the external clock with its interrupt.
    task automatic t_fail;
        int n;
        rst(3'h0, 1'b0, 1'b1);
        apb(1'b1, scss_pkg::ADDR_OSC_CTRL, 32'h61);
        apb(1'b0, scss_pkg::ADDR_OSC_CTRL, 32'h0);
        check(rd[3], 32'h0, "select internal");
        apb(1'b1, scss_pkg::ADDR_OSC_CTRL, 32'h60);
        apb(1'b0, scss_pkg::ADDR_OSC_CTRL, 32'h0);
        check(rd[3], 32'h1, "select configured");
        apb(1'b1, scss_pkg::ADDR_INT_ENABLE, 32'h1);
        check({31'h0, irq}, 32'h0, "quiet irq");
        run <= 1'b0;
        n = 0;
        while (irq !== 1'b1 && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        check({31'h0, irq}, 32'h1, "fail irq");
        apb(1'b0, scss_pkg::ADDR_OSC_CTRL, 32'h0);
        check(rd[3], 32'h0, "fallback internal");
        apb(1'b1, scss_pkg::ADDR_INT_ENABLE, 32'h0);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0, "masked irq");
        apb(1'b1, scss_pkg::ADDR_INT_ENABLE, 32'h1);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h1, "unmasked irq");
        apb(1'b1, scss_pkg::ADDR_INT_CLEAR, 32'h7);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0, "cleared irq");
        run <= 1'b1;
        $display("test fail done");
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Main sequence.
    initial begin
        t_regs();
        t_modes();
        t_freq();
        t_ost();
        t_fail();
        test_done();
    end
endmodule
`default_nettype wire
